/* File: src/touch_event_irq.sv */
// touch event qualification: interrupts, repeat, touch limit and pattern detection
//
// Function
// - per-input interrupt enable, all set at reset
// - enabled input touch raises interrupt; release too when release interrupt enabled
// - repeat off: interrupts only at touch, release
// - repeat on: periodic interrupts while held long
// - short touch: touch and release interrupts
// - blocking disabled never blocks touches; resets enabled
// - blocking flags limit count, blocks the rest
// - keep flagged inputs until a flagged release
// - after release, flag first N in order
// - limit field 00..11 means 1..4 touches
// - limit exceeded sets many-touch flag, full threshold
// - pattern detection only when enable bit set
// - pattern threshold 12.5, 25, 37.5, 100 percent
// - base threshold: touch threshold or standby threshold
// - match mode: all members above or noisy
// - count mode: enough inputs above or noisy
// - pattern event blocks touches, sets status flag
// - alert on pattern only when alert enabled
// - block while pattern condition holds, then restore
// - pattern flag clears by host after condition ends
// - hold time 35 ms steps decides press-and-hold
// - pattern member bits, all set at reset
module touch_event_irq import touch_event_pkg::*; #(
    parameter int HOLD_STEP = HOLD_STEP_CYCLES,  // cycles per hold time step
    parameter int REPEAT    = REPEAT_CYCLES      // cycles between repeat interrupts
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // register access from the host interface
    input  wire reg_req_type     reg_req,
    output logic [7:0]           reg_rdata,
    // global interrupt bit written to zero, release interrupt enable
    input  wire logic            int_clear,
    input  wire logic            release_irq_enable,
    // measurement results and thresholds
    input  wire sample_type      sample,
    input  wire logic [7:0][6:0] touch_thresh,
    input  wire logic [6:0]      standby_thresh,
    input  wire logic            standby,
    // status toward the host
    output logic [7:0]           touch_status,
    output logic                 many_touch_flag,
    output logic                 pattern_hit_flag,
    output logic                 int_status,
    output logic                 alert_n
);

    // configuration registers
    logic [7:0] hold_time_reg;          // press-and-hold code in low nibble
    logic [7:0] touch_irq_enable_reg;   // one enable per input
    logic [7:0] hold_repeat_enable_reg; // one repeat enable per input
    logic [7:0] touch_limit_config_reg; // block enable and limit
    logic [7:0] pattern_detect_config_reg;
    logic [7:0] pattern_member_reg;     // pattern members or required count

    // qualification state
    logic [7:0] flagged_reg;            // inputs currently reported as touched
    logic [7:0] flagged_next;
    logic       pat_cond_reg;           // pattern condition from last polling cycle
    logic       pat_cond_next;
    logic       pend_next;
    logic [7:0] raw_touch;              // above full threshold
    logic [7:0] pat_above;              // above pattern threshold or noisy
    logic [7:0] touch_ev;
    logic [7:0] release_ev;
    logic [7:0] repeat_ev;
    logic       pattern_ev;
    logic       over_limit;

    // per-input hold and repeat timers
    logic [TIMER_W-1:0] hold_cnt_reg [8];
    logic [7:0]         held_reg;       // press-and-hold reached

    // field decode
    logic                touch_limit_block_enable;
    logic [1:0]          touch_limit_count;
    logic                pattern_detect_enable;
    logic [1:0]          pattern_threshold_sel;
    logic                pattern_match_mode;
    logic                pattern_irq_enable;
    logic [3:0]          limit_n;
    logic [TIMER_W-1:0]  hold_limit;

    assign touch_limit_block_enable = touch_limit_config_reg[BLOCK_EN_BIT];
    assign touch_limit_count        = touch_limit_config_reg[LIMIT_LSB +: 2];
    assign pattern_detect_enable    = pattern_detect_config_reg[PAT_EN_BIT];
    assign pattern_threshold_sel    = pattern_detect_config_reg[PAT_TH_LSB +: 2];
    assign pattern_match_mode       = pattern_detect_config_reg[PAT_MODE_BIT];
    assign pattern_irq_enable       = pattern_detect_config_reg[PAT_IRQ_EN_BIT];
    // limit code 00..11 stands for 1..4 touches
    assign limit_n    = {2'b00, touch_limit_count} + 4'd1;
    // hold time is (code + 1) steps of 35 ms
    assign hold_limit = TIMER_W'((hold_time_reg[3:0] + 1) * HOLD_STEP);

    // number of set bits in a mask
    function automatic logic [3:0] popcount(input logic [7:0] m);
        logic [3:0] c;
        c = 4'd0;
        for (int i = 0; i < 8; i++) begin
            c = c + {3'b000, m[i]};
        end
        return c;
    endfunction

    // first n set bits of a mask, input 1 first
    function automatic logic [7:0] first_n(input logic [7:0] m, input logic [3:0] n);
        logic [7:0] r;
        logic [3:0] c;
        r = 8'h00;
        c = 4'd0;
        for (int i = 0; i < 8; i++) begin
            if (m[i] && c < n) begin
                r[i] = 1'b1;
                c = c + 4'd1;
            end
        end
        return r;
    endfunction

    // scale a base threshold by the pattern selector
    function automatic logic [6:0] scale_th(input logic [6:0] th, input logic [1:0] sel);
        logic [6:0] r;
        case (pat_th_type'(sel))
            PAT_TH_EIGHTH:   r = th >> 3;
            PAT_TH_QUARTER:  r = th >> 2;
            PAT_TH_3EIGHTHS: r = (th >> 2) + (th >> 3);
            PAT_TH_FULL:     r = th;
            default:         r = th;
        endcase
        return r;
    endfunction

    // threshold comparison for every input
    always_comb begin
        logic [6:0] base;
        base = 7'h00;
        raw_touch = 8'h00;
        pat_above = 8'h00;
        for (int i = 0; i < 8; i++) begin
            // standby uses the shared standby threshold
            base = standby ? standby_thresh : touch_thresh[i];
            raw_touch[i] = sample.delta[i] > {1'b0, base};
            pat_above[i] = (sample.delta[i] > {1'b0, scale_th(base, pattern_threshold_sel)})
                           || sample.noise[i];
        end
    end

    // pattern condition, evaluated once per polling cycle
    always_comb begin
        pat_cond_next = pat_cond_reg;
        if (sample.valid) begin
            if (!pattern_detect_enable) begin
                pat_cond_next = 1'b0;
            end else if (pattern_match_mode) begin
                // every member must be above or noisy
                pat_cond_next = &(pat_above | ~pattern_member_reg);
            end else begin
                // member bits only give a count here
                pat_cond_next = popcount(pat_above) >= popcount(pattern_member_reg);
            end
        end
    end

    assign pattern_ev = sample.valid && pat_cond_next && !pat_cond_reg;
    assign over_limit = touch_limit_block_enable && (popcount(raw_touch) > limit_n);

    // which inputs get reported this polling cycle
    always_comb begin
        logic [7:0] keep;
        keep = flagged_reg & raw_touch;
        flagged_next = flagged_reg;
        if (sample.valid) begin
            if (pat_cond_next) begin
                // everything blocked while the pattern stands
                flagged_next = 8'h00;
            end else if (!touch_limit_block_enable) begin
                flagged_next = raw_touch;
            end else if (keep != flagged_reg || popcount(keep) > limit_n) begin
                // a flagged pad let go: re-pick in scan order
                flagged_next = first_n(raw_touch, limit_n);
            end else begin
                // hold on to the valid ones, fill free slots only
                flagged_next = keep | first_n(raw_touch & ~keep,
                                              limit_n - popcount(keep));
            end
        end
    end

    // touch and release edges, masked per input
    assign touch_ev   = flagged_next & ~flagged_reg & touch_irq_enable_reg;
    assign release_ev = flagged_reg & ~flagged_next & touch_irq_enable_reg
                        & {8{release_irq_enable}};

    // pending interrupt: new events win over a clear in the same cycle
    assign pend_next = (|touch_ev) || (|release_ev) || (|repeat_ev)
                       || (pattern_ev && pattern_irq_enable)
                       || (int_status && !int_clear);

    // register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_time_reg             <= HOLD_TIME_RESET;
            touch_irq_enable_reg      <= TOUCH_IRQ_EN_RESET;
            hold_repeat_enable_reg    <= HOLD_REPEAT_EN_RESET;
            touch_limit_config_reg    <= TOUCH_LIMIT_RESET;
            pattern_detect_config_reg <= PATTERN_CFG_RESET;
            pattern_member_reg        <= PATTERN_MEMBER_RESET;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                HOLD_TIME_ADDR:      hold_time_reg <= reg_req.wdata & HOLD_TIME_MASK;
                TOUCH_IRQ_EN_ADDR:   touch_irq_enable_reg <= reg_req.wdata;
                HOLD_REPEAT_EN_ADDR: hold_repeat_enable_reg <= reg_req.wdata;
                TOUCH_LIMIT_ADDR:    touch_limit_config_reg <= reg_req.wdata & TOUCH_LIMIT_MASK;
                PATTERN_CFG_ADDR:    pattern_detect_config_reg <= reg_req.wdata & PATTERN_CFG_MASK;
                PATTERN_MEMBER_ADDR: pattern_member_reg <= reg_req.wdata;
                default: ;  // unmapped writes are dropped
            endcase
        end
    end

    // register reads, answered one cycle after the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                HOLD_TIME_ADDR:      reg_rdata <= hold_time_reg;
                TOUCH_IRQ_EN_ADDR:   reg_rdata <= touch_irq_enable_reg;
                HOLD_REPEAT_EN_ADDR: reg_rdata <= hold_repeat_enable_reg;
                TOUCH_LIMIT_ADDR:    reg_rdata <= touch_limit_config_reg;
                PATTERN_CFG_ADDR:    reg_rdata <= pattern_detect_config_reg;
                PATTERN_MEMBER_ADDR: reg_rdata <= pattern_member_reg;
                default:             reg_rdata <= 8'h00;  // unmapped reads zero
            endcase
        end
    end

    // touch state and pattern condition
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flagged_reg  <= 8'h00;
            touch_status <= 8'h00;
            pat_cond_reg <= 1'b0;
        end else begin
            flagged_reg  <= flagged_next;
            touch_status <= flagged_next;
            pat_cond_reg <= pat_cond_next;
        end
    end

    // per-input hold timer, then repeat timer once held
    // one counter serves both phases to save area
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                hold_cnt_reg[i] <= '0;
            end
            held_reg  <= 8'h00;
            repeat_ev <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                repeat_ev[i] <= 1'b0;
                if (!flagged_reg[i] || !hold_repeat_enable_reg[i]) begin
                    // no repeat: only edges count, however long
                    hold_cnt_reg[i] <= '0;
                    held_reg[i]     <= 1'b0;
                end else if (!held_reg[i]) begin
                    // still a short touch until the hold time passes
                    if (hold_cnt_reg[i] >= hold_limit) begin
                        held_reg[i]     <= 1'b1;
                        hold_cnt_reg[i] <= '0;
                    end else begin
                        hold_cnt_reg[i] <= hold_cnt_reg[i] + 1'b1;
                    end
                end else if (hold_cnt_reg[i] >= TIMER_W'(REPEAT - 1)) begin
                    // press-and-hold: interrupt each repeat interval
                    repeat_ev[i]    <= touch_irq_enable_reg[i];
                    hold_cnt_reg[i] <= '0;
                end else begin
                    hold_cnt_reg[i] <= hold_cnt_reg[i] + 1'b1;
                end
            end
        end
    end

    // global interrupt bit and alert pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_status <= 1'b0;
            alert_n    <= 1'b1;
        end else begin
            int_status <= pend_next;
            alert_n    <= !pend_next;
        end
    end

    // status flags: set wins; only the pattern flag clear needs the cause gone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pattern_hit_flag <= 1'b0;
            many_touch_flag  <= 1'b0;
        end else begin
            if (pattern_ev) begin
                // set whether or not the alert is enabled
                pattern_hit_flag <= 1'b1;
            end else if (int_clear && !pat_cond_reg && !pat_cond_next) begin
                pattern_hit_flag <= 1'b0;
            end
            if (sample.valid && over_limit) begin
                many_touch_flag <= 1'b1;
            end else if (int_clear) begin
                many_touch_flag <= 1'b0;
            end
        end
    end

endmodule

/* File: src/touch_event_pkg.sv */
// shared constants and carrier types for touch event qualification
package touch_event_pkg;

    // register offsets
    localparam logic [7:0] HOLD_TIME_ADDR       = 8'h23;
    localparam logic [7:0] TOUCH_IRQ_EN_ADDR    = 8'h27;
    localparam logic [7:0] HOLD_REPEAT_EN_ADDR  = 8'h28;
    localparam logic [7:0] TOUCH_LIMIT_ADDR     = 8'h2A;
    localparam logic [7:0] PATTERN_CFG_ADDR     = 8'h2B;
    localparam logic [7:0] PATTERN_MEMBER_ADDR  = 8'h2D;

    // values after reset
    localparam logic [7:0] HOLD_TIME_RESET      = 8'h07;
    localparam logic [7:0] TOUCH_IRQ_EN_RESET   = 8'hFF;
    localparam logic [7:0] HOLD_REPEAT_EN_RESET = 8'hFF;
    localparam logic [7:0] TOUCH_LIMIT_RESET    = 8'h80;
    localparam logic [7:0] PATTERN_CFG_RESET    = 8'h00;
    localparam logic [7:0] PATTERN_MEMBER_RESET = 8'hFF;

    // writable bits of each register, the rest read as zero
    localparam logic [7:0] HOLD_TIME_MASK       = 8'h0F;
    localparam logic [7:0] TOUCH_LIMIT_MASK     = 8'h8C;
    localparam logic [7:0] PATTERN_CFG_MASK     = 8'h8F;

    // field positions
    localparam int BLOCK_EN_BIT    = 7;
    localparam int LIMIT_LSB       = 2;
    localparam int PAT_EN_BIT      = 7;
    localparam int PAT_TH_LSB      = 2;
    localparam int PAT_MODE_BIT    = 1;
    localparam int PAT_IRQ_EN_BIT  = 0;

    // timing: hold time step and a plain default repeat interval
    localparam int CLK_FREQ_KHZ      = 25000;
    localparam int HOLD_STEP_MS      = 35;
    localparam int HOLD_STEP_CYCLES  = HOLD_STEP_MS * CLK_FREQ_KHZ;
    localparam int REPEAT_MS         = 175;
    localparam int REPEAT_CYCLES     = REPEAT_MS * CLK_FREQ_KHZ;
    localparam int TIMER_W           = 24;

    // pattern threshold selector codes
    typedef enum logic [1:0] {
        PAT_TH_EIGHTH   = 2'b00,
        PAT_TH_QUARTER  = 2'b01,
        PAT_TH_3EIGHTHS = 2'b10,
        PAT_TH_FULL     = 2'b11
    } pat_th_type;

    // register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    // one polling cycle result from the measurement side
    typedef struct packed {
        logic            valid;
        logic [7:0]      noise;
        logic [7:0][7:0] delta;
    } sample_type;

endpackage

/* File: tb/touch_event_sva.sv */
// checker: concurrent assertions on the touch event block ports
module touch_event_sva import touch_event_pkg::*; #(
    parameter int HOLD_STEP = 10, // hold step, cycles
    parameter int REPEAT    = 20  // repeat interval, cycles
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // host and measurement side
    input wire reg_req_type reg_req,
    input wire logic        int_clear,
    input wire sample_type  sample,
    // watched outputs
    input wire logic [7:0]  touch_status,
    input wire logic        pattern_hit_flag,
    input wire logic        int_status,
    input wire logic        alert_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ie_reg;  // interrupt enables
    logic [7:0] rpt_reg; // repeat enables
    logic [7:0] lim_reg; // touch limit config
    logic [7:0] pat_reg; // pattern config
    // shadows follow host writes, masked as in the block
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ie_reg  <= 8'hFF;
            rpt_reg <= 8'hFF;
            lim_reg <= 8'h80;
            pat_reg <= 8'h00;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                TOUCH_IRQ_EN_ADDR:   ie_reg <= reg_req.wdata;
                HOLD_REPEAT_EN_ADDR: rpt_reg <= reg_req.wdata;
                TOUCH_LIMIT_ADDR:    lim_reg <= reg_req.wdata & 8'h8C;
                PATTERN_CFG_ADDR:    pat_reg <= reg_req.wdata & 8'h8F;
                default:             ;
            endcase
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // clear with no sample and no repeat source pending
    sequence s_quiet_clear;
        int_clear && !sample.valid && rpt_reg == 8'h00;
    endsequence
    // pattern event seen at the outputs
    sequence s_pat_event;
        $rose(pattern_hit_flag);
    endsequence
    property p_alert; alert_n == !int_status; endproperty
    a_alert: assert property (p_alert) else $error("alert not inverse of status");
    property p_touch_irq; (|(touch_status & ~$past(touch_status) & ie_reg)) |-> int_status; endproperty
    a_touch_irq: assert property (p_touch_irq) else $error("touch gave no irq");
    property p_rpt_off; $rose(int_status) && rpt_reg == 8'h00 |-> $past(sample.valid); endproperty
    a_rpt_off: assert property (p_rpt_off) else $error("irq without sample");
    property p_clear; s_quiet_clear |=> !int_status; endproperty
    a_clear: assert property (p_clear) else $error("clear did not drop irq");
    property p_int_fall; $fell(int_status) |-> $past(int_clear); endproperty
    a_int_fall: assert property (p_int_fall) else $error("irq dropped by itself");
    property p_limit; lim_reg[7] |-> $countones(touch_status) <= int'(lim_reg[3:2]) + 1; endproperty
    a_limit: assert property (p_limit) else $error("too many flagged touches");
    property p_hold; $changed(touch_status) |-> $past(sample.valid); endproperty
    a_hold: assert property (p_hold) else $error("status moved without sample");
    property p_pat_blocks; s_pat_event |-> touch_status == 8'h00; endproperty
    a_pat_blocks: assert property (p_pat_blocks) else $error("pattern did not block");
    property p_pat_off; !pat_reg[7] |-> !$rose(pattern_hit_flag); endproperty
    a_pat_off: assert property (p_pat_off) else $error("pattern while disabled");
    property p_pat_alert; s_pat_event ##0 pat_reg[0] |-> int_status; endproperty
    a_pat_alert: assert property (p_pat_alert) else $error("pattern alert missing");
    property p_pat_clear; $fell(pattern_hit_flag) |-> $past(int_clear); endproperty
    a_pat_clear: assert property (p_pat_clear) else $error("pattern flag fell alone");
endmodule

bind touch_event_irq touch_event_sva #(.HOLD_STEP(HOLD_STEP), .REPEAT(REPEAT)) touch_event_sva_inst (
    .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .int_clear(int_clear), .sample(sample),
    .touch_status(touch_status), .pattern_hit_flag(pattern_hit_flag),
    .int_status(int_status), .alert_n(alert_n));

/* File: tb/host_model.sv */
// host controller model: register cycles and interrupt clearing
module host_model import touch_event_pkg::*; (
    // clock
    input  wire logic   clk,
    // toward the block
    output reg_req_type reg_req,
    output logic        int_clear,
    output logic        release_irq_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    bit slow = 1'b0; // idles before each request when set
    initial begin
        reg_req            = '0;
        int_clear          = 1'b0;
        release_irq_enable = 1'b1;
    end
    // one register cycle, taken at the next edge
    task automatic req(input logic w, input logic [7:0] a, input logic [7:0] d);
        if (slow) repeat (3) @(posedge clk);
        @(posedge clk) reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        // released bus shows inverted leftovers, never the last value
        @(posedge clk) reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // host writes zero to the global interrupt bit
    task automatic clr;
        @(posedge clk) int_clear <= 1'b1;
        @(posedge clk) int_clear <= 1'b0;
    endtask
    // release interrupt setting, a level
    task automatic rel(input logic v);
        @(posedge clk) release_irq_enable <= v;
    endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for touch event qualification
module testbench import touch_event_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic            clk = 1'b0;                // bench clock
    logic            rst_n = 1'b0;              // reset, active low
    reg_req_type     reg_req;                   // host requests
    logic            int_clear, release_irq_enable;
    sample_type      sample = '0;               // polling result
    logic [7:0][6:0] touch_thresh = {8{7'h28}}; // forty on each input
    logic [6:0]      standby_thresh = 7'h50;    // eighty in standby
    logic            standby = 1'b0;            // power state
    logic [7:0]      reg_rdata, touch_status;
    logic            many_touch_flag, pattern_hit_flag, int_status, alert_n;
    logic [7:0]      rq[$];                     // expected read data
    logic [11:0]     oq[$];                     // expected status and flags
    logic            rd_d = 1'b0, obs = 1'b0;   // result due markers
    logic [7:0]      nz = 8'h00, t;             // noise flags, touch mask
    logic [6:0]      dv;                        // random touch delta
    logic [6:0]      pth[4] = '{7'd5, 7'd10, 7'd15, 7'd40}; // pattern thresholds at forty
    int              num_errors = 0, checked = 0, seed = 53847;

    always #20 clk = ~clk;

    touch_event_irq #(.HOLD_STEP(10), .REPEAT(20)) touch_event_irq_inst (
        .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .int_clear(int_clear), .release_irq_enable(release_irq_enable), .sample(sample),
        .touch_thresh(touch_thresh), .standby_thresh(standby_thresh), .standby(standby),
        .touch_status(touch_status), .many_touch_flag(many_touch_flag),
        .pattern_hit_flag(pattern_hit_flag), .int_status(int_status), .alert_n(alert_n));
    host_model host_model_inst (.clk(clk), .reg_req(reg_req), .int_clear(int_clear),
        .release_irq_enable(release_irq_enable));

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // monitor: takes the oldest note whenever a result is due
    always @(posedge clk) begin
        rd_d <= reg_req.rd;
        if (rd_d) check("reg_rdata", {4'h0, reg_rdata}, {4'h0, rq.pop_front()});
        if (obs) check("status", {touch_status, many_touch_flag, pattern_hit_flag,
            int_status, alert_n}, oq.pop_front());
    end
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        rq.push_back(e);
        host_model_inst.req(1'b0, a, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_model_inst.req(1'b1, a, d);
    endtask
    // one polling cycle (or none when v is low), then outputs are noted
    task automatic ev(input logic [7:0] m, input logic [6:0] d, input bit v, input logic [11:0] e);
        sample_type s;
        s = '0;
        s.valid = v;
        s.noise = nz;
        for (int i = 0; i < 8; i++) if (m[i]) s.delta[i] = {1'b0, d};
        @(posedge clk) sample <= s;
        @(posedge clk) sample.valid <= 1'b0;
        @(posedge clk) obs <= 1'b1;
        oq.push_back(e);
        @(posedge clk) obs <= 1'b0;
    endtask
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard, well past the run
    initial begin
        #400us;
        num_errors++;
        end_of_test;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rdx(TOUCH_IRQ_EN_ADDR, 8'hFF);
        rdx(HOLD_REPEAT_EN_ADDR, 8'hFF);
        rdx(TOUCH_LIMIT_ADDR, 8'h80);
        rdx(PATTERN_CFG_ADDR, 8'h00);
        rdx(PATTERN_MEMBER_ADDR, 8'hFF);
        rdx(HOLD_TIME_ADDR, 8'h07);
        rdx(8'h29, 8'h00);
        wr(TOUCH_LIMIT_ADDR, 8'hFF);
        rdx(TOUCH_LIMIT_ADDR, 8'h8C);
        wr(PATTERN_CFG_ADDR, 8'hFF);
        rdx(PATTERN_CFG_ADDR, 8'h8F);
        wr(PATTERN_CFG_ADDR, 8'h00);
        wr(TOUCH_LIMIT_ADDR, 8'h00);
        $display("test registers done");
        // short touches, blocking off, random inputs and strength
        t = 8'($random(seed)) | 8'h01;
        dv = 7'h40 | 7'($random(seed));
        ev(t, dv, 1'b1, {t, 4'h2});
        host_model_inst.clr;
        ev(8'h00, dv, 1'b0, {t, 4'h1});
        ev(8'h00, dv, 1'b1, {8'h00, 4'h2});
        host_model_inst.clr;
        wr(TOUCH_IRQ_EN_ADDR, 8'hFE);
        host_model_inst.rel(1'b0);
        ev(8'h01, dv, 1'b1, {8'h01, 4'h1});
        ev(8'h00, dv, 1'b1, {8'h00, 4'h1});
        host_model_inst.rel(1'b1);
        wr(TOUCH_IRQ_EN_ADDR, 8'hFF);
        $display("test interrupts done");
        host_model_inst.slow = 1'b1;
        for (int n = 0; n < 4; n++) begin
            wr(TOUCH_LIMIT_ADDR, 8'h80 | 8'(n << 2));
            host_model_inst.clr;
            ev(8'hFF, dv, 1'b1, {8'((16'h1 << (n + 1)) - 1), 4'hA});
            ev(8'h00, dv, 1'b1, {8'h00, 4'hA});
        end
        wr(TOUCH_LIMIT_ADDR, 8'h84);
        host_model_inst.clr;
        ev(8'hAA, dv, 1'b1, {8'h0A, 4'hA});
        ev(8'hAB, dv, 1'b1, {8'h0A, 4'hA});
        ev(8'hA9, dv, 1'b1, {8'h09, 4'hA});
        ev(8'h00, dv, 1'b1, {8'h00, 4'hA});
        host_model_inst.clr;
        $display("test blocking done");
        wr(TOUCH_LIMIT_ADDR, 8'h00);
        ev(8'h01, dv, 1'b1, {8'h01, 4'h2});
        host_model_inst.clr;
        repeat (130) @(posedge clk);
        ev(8'h00, dv, 1'b0, {8'h01, 4'h2});
        ev(8'h00, dv, 1'b1, {8'h00, 4'h2});
        host_model_inst.clr;
        wr(HOLD_REPEAT_EN_ADDR, 8'h00);
        ev(8'h01, dv, 1'b1, {8'h01, 4'h2});
        host_model_inst.clr;
        repeat (130) @(posedge clk);
        ev(8'h00, dv, 1'b0, {8'h01, 4'h1});
        ev(8'h00, dv, 1'b1, {8'h00, 4'h2});
        host_model_inst.clr;
        $display("test repeat done");
        // match mode on inputs one and three, each threshold code at its edge
        wr(PATTERN_MEMBER_ADDR, 8'h05);
        for (int c = 0; c < 4; c++) begin
            wr(PATTERN_CFG_ADDR, 8'h83 | 8'(c << 2));
            ev(8'h05, pth[c], 1'b1, {8'h00, 4'h1});
            ev(8'h05, pth[c] + 7'd1, 1'b1, {8'h00, 4'h6});
            ev(8'h00, 7'h00, 1'b1, {8'h00, 4'h6});
            host_model_inst.clr;
        end
        wr(PATTERN_CFG_ADDR, 8'h83);
        ev(8'h05, 7'h30, 1'b1, {8'h00, 4'h6});
        host_model_inst.clr;
        ev(8'h05, 7'h30, 1'b1, {8'h00, 4'h5});
        ev(8'h01, 7'h30, 1'b1, {8'h01, 4'h6});
        host_model_inst.clr;
        ev(8'h00, 7'h00, 1'b0, {8'h01, 4'h1});
        ev(8'h00, 7'h00, 1'b1, {8'h00, 4'h2});
        host_model_inst.clr;
        wr(PATTERN_CFG_ADDR, 8'h80);
        nz = 8'h10;
        ev(8'h40, 7'h06, 1'b1, {8'h00, 4'h5});
        nz = 8'h00;
        ev(8'h00, 7'h00, 1'b1, {8'h00, 4'h5});
        host_model_inst.clr;
        wr(PATTERN_CFG_ADDR, 8'h03);
        ev(8'h05, 7'h30, 1'b1, {8'h05, 4'h2});
        ev(8'h00, 7'h00, 1'b1, {8'h00, 4'h2});
        host_model_inst.clr;
        @(posedge clk) standby <= 1'b1;
        wr(PATTERN_CFG_ADDR, 8'h82);
        ev(8'h05, 7'h0A, 1'b1, {8'h00, 4'h1});
        ev(8'h05, 7'h0B, 1'b1, {8'h00, 4'h5});
        $display("test pattern done");
        end_of_test;
    end
endmodule
